// ===== src/ic_pkg.sv
// shared constants and types of the vectored interrupt controller
package ic_pkg;
  localparam int NSRC  = 32;
  localparam int LVL_W = 3;
  localparam int SRC_W = 5;
  localparam int TRIG_W = 2;
  localparam int DEPTH = 8;
  localparam int DEPTH_W = 4;
  localparam int STK_W = 3;
  localparam int AW = 12;
  localparam int DW = 32;
  localparam logic [DEPTH_W-1:0] DEPTH_MAX = 4'h8;
  localparam logic [DEPTH_W-1:0] DEPTH_ONE = 4'h1;
  // register byte offsets
  localparam logic [AW-1:0] MODE_BASE       = 12'h000;
  localparam logic [AW-1:0] HANDLER_BASE    = 12'h080;
  localparam logic [AW-1:0] VECTOR_OFS      = 12'h100;
  localparam logic [AW-1:0] FAST_VECTOR_OFS = 12'h104;
  localparam logic [AW-1:0] CURRENT_OFS     = 12'h108;
  localparam logic [AW-1:0] PENDING_OFS     = 12'h10C;
  localparam logic [AW-1:0] MASK_OFS        = 12'h110;
  localparam logic [AW-1:0] LINE_OFS        = 12'h114;
  localparam logic [AW-1:0] FORCE_OFS       = 12'h118;
  localparam logic [AW-1:0] ENABLE_OFS      = 12'h120;
  localparam logic [AW-1:0] DISABLE_OFS     = 12'h124;
  localparam logic [AW-1:0] CLEAR_OFS       = 12'h128;
  localparam logic [AW-1:0] SET_OFS         = 12'h12C;
  localparam logic [AW-1:0] EOS_OFS         = 12'h130;
  // address slicing of the two banks
  localparam int IDX_LSB  = 2;
  localparam int BANK_LSB = 7;
  // source mode word layout and trigger bits
  localparam int PRIO_LSB = 0;
  localparam int TYPE_LSB = 5;
  localparam int TRIG_EDGE = 0;
  localparam int TRIG_POS  = 1;
  // core line status bits
  localparam int LINE_FAST_BIT   = 0;
  localparam int LINE_NORMAL_BIT = 1;
  localparam logic [NSRC-1:0] FAST_SRC_BIT = 32'h0000_0001;

  typedef enum logic [0:0] {PH_IDLE = 1'b0, PH_WAIT = 1'b1} phase_t;
  typedef struct packed {
    logic [TRIG_W-1:0] trig;
    logic [LVL_W-1:0]  prio;
  } mode_t;
  typedef struct packed {
    logic [SRC_W-1:0] src;
    logic [LVL_W-1:0] lvl;
  } frame_t;
endpackage

// ===== src/hmem_if.sv
// write and read port of the handler address table
interface hmem_if #(
  parameter int AW = 5,
  parameter int DW = 32
);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ===== src/handler_table.sv
// handler address table with registered read data
module handler_table #(
  parameter int AW = 5,
  parameter int DW = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  hmem_if.mem      port
);
  typedef struct packed {
    logic [(1<<AW)-1:0][DW-1:0] word;
    logic [DW-1:0]              rd;
  } table_t;
  table_t s_q;
  table_t s_d;

  // write port and registered read
  always_comb begin
    s_d = s_q;
    if (port.we) begin
      s_d.word[port.waddr] = port.wdata;
    end
    s_d.rd = s_q.word[port.raddr];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign port.rdata = s_q.rd;
endmodule

// ===== src/source_stage.sv
// one interrupt source: synchroniser, trigger detection and edge memory
module source_stage #(
  parameter bit EXT = 1'b0
) (
  input wire logic                      clk,
  input wire logic                      rst_n,
  input wire logic                      raw,
  input wire logic [ic_pkg::TRIG_W-1:0] trig,
  input wire logic                      set_cmd,
  input wire logic                      clr_cmd,
  output logic                          pending
);
  typedef struct packed {
    logic [2:0] sync;
    logic       filt;
    logic       prev;
    logic       mem;
  } stage_t;
  stage_t s_q;
  stage_t s_d;
  logic   lvl;
  logic   cond;
  logic   edge_mode;

  // pin sampling, condition and edge memory
  always_comb begin
    s_d = s_q;
    s_d.sync = {s_q.sync[1:0], raw};
    if (s_q.sync[2] == s_q.sync[1]) begin
      s_d.filt = s_q.sync[2];
    end
    lvl = EXT ? s_q.filt : raw;
    cond = (trig[ic_pkg::TRIG_POS] || !EXT) ? lvl : !lvl;
    edge_mode = trig[ic_pkg::TRIG_EDGE];
    s_d.prev = cond;
    // set wins over clear; level mode keeps no memory
    s_d.mem = edge_mode & ((s_q.mem & !clr_cmd) | (cond & !s_q.prev) | set_cmd);
    pending = edge_mode ? s_q.mem : cond;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_set_wins;
    (trig[ic_pkg::TRIG_EDGE] && set_cmd) |=> s_q.mem;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set command lost");

  property p_level_no_memory;
    !trig[ic_pkg::TRIG_EDGE] |=> !s_q.mem;
  endproperty
  a_level_no_memory: assert property (p_level_no_memory) else $error("level memory set");
endmodule

// ===== src/vectored_irq_ctrl.sv
// vectored priority interrupt controller with APB register slave
module vectored_irq_ctrl #(
  parameter logic [ic_pkg::NSRC-1:0] EXT_MASK = 32'h8000_0001
) (
  input  wire logic                      CLOCK,
  input  wire logic                      RST_N,
  input  wire logic                      PSEL,
  input  wire logic                      PENABLE,
  input  wire logic                      PWRITE,
  input  wire logic [ic_pkg::AW-1:0]     PADDR,
  input  wire logic [ic_pkg::DW-1:0]     PWDATA,
  output logic      [ic_pkg::DW-1:0]     PRDATA,
  output logic                           PREADY,
  output logic                           PSLVERR,
  input  wire logic                      FAST_SOURCE_INPUT,
  input  wire logic [ic_pkg::NSRC-1:1]   SOURCE_IN,
  output logic                           NORMAL_REQUEST_N,
  output logic                           FAST_REQUEST_N
);
  typedef struct packed {
    ic_pkg::mode_t [ic_pkg::NSRC-1:0]   mode;
    logic [ic_pkg::NSRC-1:0]            mask;
    logic [ic_pkg::NSRC-1:0]            force_fast;
    ic_pkg::frame_t [ic_pkg::DEPTH-1:0] stack;
    ic_pkg::frame_t                     cur;
    logic [ic_pkg::DEPTH_W-1:0]         depth;
    ic_pkg::phase_t                     phase;
    logic [ic_pkg::SRC_W-1:0]           sel;
    logic                               found;
    logic                               from_mem;
    logic [ic_pkg::DW-1:0]              rdata;
    logic                               slverr;
    logic                               normal;
    logic                               fast;
  } ctl_t;

  ctl_t                      s_q;
  ctl_t                      s_d;
  logic [ic_pkg::NSRC-1:0]   pend;
  logic [ic_pkg::NSRC-1:0]   raw_in;
  logic [ic_pkg::NSRC-1:0]   cand;
  logic [ic_pkg::NSRC-1:0]   set_vec;
  logic [ic_pkg::NSRC-1:0]   clr_vec;
  logic                      any_above;
  logic                      best_found;
  logic [ic_pkg::SRC_W-1:0]  best_src;
  logic [ic_pkg::LVL_W-1:0]  best_lvl;
  logic                      access;
  logic                      done;
  logic                      wr_done;
  logic                      rd_done;
  logic                      ivr_done;
  logic                      fvr_done;
  logic                      is_mode;
  logic                      is_hand;
  logic                      known;
  logic [ic_pkg::SRC_W-1:0]  idx;
  logic [ic_pkg::STK_W-1:0]  push_idx;
  logic [ic_pkg::STK_W-1:0]  pop_idx;

  hmem_if #(.AW(ic_pkg::SRC_W), .DW(ic_pkg::DW)) hm ();

  handler_table #(.AW(ic_pkg::SRC_W), .DW(ic_pkg::DW)) u_table (
    .clk   (CLOCK),
    .rst_n (RST_N),
    .port  (hm.mem)
  );

  // per-source trigger stages, source zero on the fast pin
  assign raw_in = {SOURCE_IN, FAST_SOURCE_INPUT};
  for (genvar g = 0; g < ic_pkg::NSRC; g++) begin : g_src
    source_stage #(.EXT(EXT_MASK[g])) u_stage (
      .clk     (CLOCK),
      .rst_n   (RST_N),
      .raw     (raw_in[g]),
      .trig    (s_q.mode[g].trig),
      .set_cmd (set_vec[g]),
      .clr_cmd (clr_vec[g]),
      .pending (pend[g])
    );
  end

  // bus phase and address decode
  assign access   = PSEL & PENABLE;
  assign done     = access & (s_q.phase == ic_pkg::PH_WAIT);
  assign wr_done  = done & PWRITE;
  assign rd_done  = done & !PWRITE;
  assign ivr_done = rd_done & (PADDR == ic_pkg::VECTOR_OFS);
  assign fvr_done = rd_done & (PADDR == ic_pkg::FAST_VECTOR_OFS);
  assign idx      = PADDR[ic_pkg::IDX_LSB +: ic_pkg::SRC_W];
  assign is_mode  = PADDR[ic_pkg::AW-1:ic_pkg::BANK_LSB]
                    == ic_pkg::MODE_BASE[ic_pkg::AW-1:ic_pkg::BANK_LSB];
  assign is_hand  = PADDR[ic_pkg::AW-1:ic_pkg::BANK_LSB]
                    == ic_pkg::HANDLER_BASE[ic_pkg::AW-1:ic_pkg::BANK_LSB];
  assign known    = PADDR inside {ic_pkg::VECTOR_OFS, ic_pkg::FAST_VECTOR_OFS,
                    ic_pkg::CURRENT_OFS, ic_pkg::PENDING_OFS, ic_pkg::MASK_OFS,
                    ic_pkg::LINE_OFS, ic_pkg::FORCE_OFS, ic_pkg::ENABLE_OFS,
                    ic_pkg::DISABLE_OFS, ic_pkg::CLEAR_OFS, ic_pkg::SET_OFS,
                    ic_pkg::EOS_OFS};
  assign push_idx = s_q.depth[ic_pkg::STK_W-1:0];
  assign pop_idx  = ic_pkg::STK_W'(s_q.depth - ic_pkg::DEPTH_ONE);

  // priority resolver over enabled, unforced sources 1 and up
  always_comb begin
    cand = pend & s_q.mask & ~s_q.force_fast;
    cand[0] = 1'b0;
    any_above = 1'b0;
    best_found = 1'b0;
    best_src = '0;
    best_lvl = '0;
    for (int i = ic_pkg::NSRC - 1; i > 0; i--) begin
      if (cand[i]) begin
        if (s_q.depth == '0 || s_q.mode[i].prio > s_q.cur.lvl) begin
          any_above = 1'b1;
        end
        if (!best_found || s_q.mode[i].prio >= best_lvl) begin
          best_found = 1'b1;
          best_src = ic_pkg::SRC_W'(i);
          best_lvl = s_q.mode[i].prio;
        end
      end
    end
  end

  // set and clear strobes toward the edge memories
  always_comb begin
    set_vec = '0;
    clr_vec = '0;
    if (wr_done && PADDR == ic_pkg::SET_OFS) begin
      set_vec = PWDATA[ic_pkg::NSRC-1:0];
    end
    if (wr_done && PADDR == ic_pkg::CLEAR_OFS) begin
      clr_vec = PWDATA[ic_pkg::NSRC-1:0];
    end
    if (ivr_done && s_q.found && !s_q.force_fast[s_q.sel]) begin
      clr_vec[s_q.sel] = 1'b1;
    end
    if (fvr_done) begin
      clr_vec[0] = 1'b1;
    end
  end

  // handler table ports
  assign hm.we    = wr_done & is_hand;
  assign hm.waddr = idx;
  assign hm.wdata = PWDATA;
  always_comb begin
    if (PADDR == ic_pkg::VECTOR_OFS) begin
      hm.raddr = best_src;
    end else if (PADDR == ic_pkg::FAST_VECTOR_OFS) begin
      hm.raddr = '0;
    end else begin
      hm.raddr = idx;
    end
  end

  // register file, service stack and request lines
  always_comb begin
    s_d = s_q;
    s_d.normal = any_above;
    s_d.fast = |(pend & s_q.mask & (s_q.force_fast | ic_pkg::FAST_SRC_BIT));
    if (access && s_q.phase == ic_pkg::PH_IDLE) begin
      s_d.phase = ic_pkg::PH_WAIT;
      s_d.sel = best_src;
      s_d.found = best_found;
      s_d.slverr = !(is_mode || is_hand || known);
      s_d.from_mem = !PWRITE && (is_hand || PADDR == ic_pkg::FAST_VECTOR_OFS
                     || (PADDR == ic_pkg::VECTOR_OFS && best_found));
      s_d.rdata = '0;
      if (!PWRITE && is_mode) begin
        s_d.rdata[ic_pkg::PRIO_LSB +: ic_pkg::LVL_W] = s_q.mode[idx].prio;
        s_d.rdata[ic_pkg::TYPE_LSB +: ic_pkg::TRIG_W] = s_q.mode[idx].trig;
      end
      if (!PWRITE) begin
        case (PADDR)
          ic_pkg::CURRENT_OFS: s_d.rdata[ic_pkg::SRC_W-1:0] = s_q.cur.src;
          ic_pkg::PENDING_OFS: s_d.rdata = pend;
          ic_pkg::MASK_OFS:    s_d.rdata = s_q.mask;
          ic_pkg::FORCE_OFS:   s_d.rdata = s_q.force_fast;
          ic_pkg::LINE_OFS: begin
            s_d.rdata[ic_pkg::LINE_FAST_BIT] = s_q.fast;
            s_d.rdata[ic_pkg::LINE_NORMAL_BIT] = s_q.normal;
          end
          default: ;
        endcase
      end
    end
    if (done) begin
      s_d.phase = ic_pkg::PH_IDLE;
      if (PWRITE && is_mode) begin
        s_d.mode[idx].prio = PWDATA[ic_pkg::PRIO_LSB +: ic_pkg::LVL_W];
        s_d.mode[idx].trig = PWDATA[ic_pkg::TYPE_LSB +: ic_pkg::TRIG_W];
      end
      if (PWRITE) begin
        case (PADDR)
          ic_pkg::ENABLE_OFS:  s_d.mask = s_q.mask | PWDATA;
          ic_pkg::DISABLE_OFS: s_d.mask = s_q.mask & ~PWDATA;
          ic_pkg::FORCE_OFS:   s_d.force_fast = PWDATA;
          ic_pkg::EOS_OFS: begin
            if (s_q.depth != '0) begin
              s_d.depth = s_q.depth - ic_pkg::DEPTH_ONE;
              s_d.cur = s_q.stack[pop_idx];
            end
          end
          default: ;
        endcase
      end else if (ivr_done) begin
        s_d.normal = 1'b0;
        if (s_q.found && s_q.depth != ic_pkg::DEPTH_MAX) begin
          s_d.stack[push_idx] = s_q.cur;
          s_d.depth = s_q.depth + ic_pkg::DEPTH_ONE;
          s_d.cur.src = s_q.sel;
          s_d.cur.lvl = s_q.mode[s_q.sel].prio;
        end
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // bus answer and active-low request lines
  assign PREADY           = done;
  assign PRDATA           = s_q.from_mem ? hm.rdata : s_q.rdata;
  assign PSLVERR          = done & s_q.slverr;
  assign NORMAL_REQUEST_N = !s_q.normal;
  assign FAST_REQUEST_N   = !s_q.fast;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  sequence s_write(logic [ic_pkg::AW-1:0] a);
    wr_done && PADDR == a;
  endsequence
  sequence s_read(logic [ic_pkg::AW-1:0] a);
    rd_done && PADDR == a;
  endsequence
  sequence s_enter;
    ivr_done && s_q.found && s_q.depth != ic_pkg::DEPTH_MAX;
  endsequence

  property p_enable_mask;
    s_write(ic_pkg::ENABLE_OFS) |=> (s_q.mask & $past(PWDATA)) == $past(PWDATA);
  endproperty
  a_enable_mask: assert property (p_enable_mask) else $error("enable lost");

  property p_disable_mask;
    s_write(ic_pkg::DISABLE_OFS) |=> (s_q.mask & $past(PWDATA)) == '0;
  endproperty
  a_disable_mask: assert property (p_disable_mask) else $error("disable lost");

  property p_vector_drop;
    s_read(ic_pkg::VECTOR_OFS) |=> NORMAL_REQUEST_N;
  endproperty
  a_vector_drop: assert property (p_vector_drop) else $error("request kept");

  property p_push;
    s_enter |=> s_q.depth == $past(s_q.depth) + ic_pkg::DEPTH_ONE
      && s_q.stack[$past(push_idx)] == $past(s_q.cur) && s_q.cur.src == $past(s_q.sel);
  endproperty
  a_push: assert property (p_push) else $error("push wrong");

  property p_pop;
    s_write(ic_pkg::EOS_OFS) ##0 s_q.depth != '0 |=> s_q.cur == $past(s_q.stack[pop_idx]);
  endproperty
  a_pop: assert property (p_pop) else $error("pop wrong");

  property p_pending_raw;
    s_read(ic_pkg::PENDING_OFS) |-> PRDATA == $past(pend);
  endproperty
  a_pending_raw: assert property (p_pending_raw) else $error("pending wrong");

  property p_lower_waits;
    !any_above |=> NORMAL_REQUEST_N;
  endproperty
  a_lower_waits: assert property (p_lower_waits) else $error("early request");

  // no enabled unforced source above zero pending: normal line stays quiet
  property p_forced_quiet;
    (pend[ic_pkg::NSRC-1:1] & s_q.mask[ic_pkg::NSRC-1:1] & ~s_q.force_fast[ic_pkg::NSRC-1:1])
      == '0 |=> NORMAL_REQUEST_N;
  endproperty
  a_forced_quiet: assert property (p_forced_quiet) else $error("forced on normal");

  property p_fast_line;
    (pend[0] && s_q.mask[0]) |=> !FAST_REQUEST_N;
  endproperty
  a_fast_line: assert property (p_fast_line) else $error("fast line idle");

  // register images returned on the read completion cycle
  property p_line_image;
    s_read(ic_pkg::LINE_OFS) |-> PRDATA[ic_pkg::LINE_FAST_BIT] == !$past(FAST_REQUEST_N)
      && PRDATA[ic_pkg::LINE_NORMAL_BIT] == !$past(NORMAL_REQUEST_N);
  endproperty
  a_line_image: assert property (p_line_image) else $error("line image wrong");

  property p_current_read;
    s_read(ic_pkg::CURRENT_OFS) |-> PRDATA[ic_pkg::SRC_W-1:0] == $past(s_q.cur.src)
      && PRDATA[ic_pkg::DW-1:ic_pkg::SRC_W] == '0;
  endproperty
  a_current_read: assert property (p_current_read) else $error("current wrong");

  property p_mask_read;
    s_read(ic_pkg::MASK_OFS) |-> PRDATA == $past(s_q.mask);
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask image wrong");

  // stack never grows past eight nested services
  property p_depth_bound;
    s_q.depth <= ic_pkg::DEPTH_MAX;
  endproperty
  a_depth_bound: assert property (p_depth_bound) else $error("stack overrun");
endmodule

// ===== dv/core_model.sv
// processor core model: samples both request lines as core inputs
module core_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic normal_n,
  input  wire logic fast_n,
  output logic      irq_seen,
  output logic      fiq_seen
);
  timeunit 1ns;
  timeprecision 1ps;

  // core takes the active-low lines one edge late
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_seen <= 1'b0;
      fiq_seen <= 1'b0;
    end else begin
      irq_seen <= ~normal_n;
      fiq_seen <= ~fast_n;
    end
  end
endmodule

// ===== dv/tb.sv
// self-checking bench of the vectored interrupt controller
`define CHK(got, exp) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    fail_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end
`define RCHK(a, exp) begin rd(a, rv); `CHK(rv, exp) end

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                   clock = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   psel = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite = 1'b0;
  logic [ic_pkg::AW-1:0]  paddr = 12'h000;
  logic [31:0]            pwdata = 32'h0;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   fast_in = 1'b1;  // external pins idle high
  logic [31:1]            src_in = 31'h4000_0000;
  logic                   normal_n;
  logic                   fast_n;
  logic                   cm_irq;
  logic                   cm_fiq;
  logic [31:0]            rv;
  logic                   err;
  logic [31:0]            hnd [32];
  int                     fail_count = 0;
  int                     tests_run = 0;

  // 20 MHz clock
  always #25 clock = ~clock;

  vectored_irq_ctrl i_dut (
    .CLOCK(clock), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .FAST_SOURCE_INPUT(fast_in),
    .SOURCE_IN(src_in), .NORMAL_REQUEST_N(normal_n), .FAST_REQUEST_N(fast_n)
  );

  core_model i_core (
    .clk(clock), .rst_n(rst_n), .normal_n(normal_n), .fast_n(fast_n),
    .irq_seen(cm_irq), .fiq_seen(cm_fiq)
  );

  task automatic final_report();
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr_en, input logic [ic_pkg::AW-1:0] a,
                     input logic [31:0] wd, output logic [31:0] rdv);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      fail_count++;
      final_report();
    end
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ic_pkg::AW-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rv);
  endtask

  task automatic rd(input logic [ic_pkg::AW-1:0] a, output logic [31:0] d);
    apb(1'b0, a, 32'h0, d);
  endtask

  // bounded wait until the core model sees a request
  task automatic wait_req(input bit fq);
    int n;
    n = 0;
    while ((fq ? cm_fiq : cm_irq) !== 1'b1 && n < 24) begin
      @(posedge clock);
      n++;
    end
    if (n >= 24) begin
      fail_count++;
      final_report();
    end
  endtask

  // expectation helpers
  function automatic logic [ic_pkg::AW-1:0] ma(input int n);
    return ic_pkg::MODE_BASE + 12'(4 * n);
  endfunction

  function automatic logic [31:0] mword(input logic [2:0] p, input logic [1:0] t);
    return {25'h0, t, 2'b00, p};
  endfunction

  // highest priority wins, lowest number on a tie
  function automatic int best(input logic [2:0] p [32], input logic [31:0] m);
    int b;
    b = -1;
    for (int i = 1; i < 32; i++) begin
      if (m[i] && (b < 0 || p[i] > p[b])) b = i;
    end
    return b;
  endfunction

  // main sequence
  initial begin
    int k;
    int w;
    logic [2:0] pr [32];
    logic [31:0] mk;
    void'($urandom(32'h54EB6BD2));
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    `RCHK(ic_pkg::MASK_OFS, 32'h0)
    `RCHK(ic_pkg::PENDING_OFS, 32'h0)
    `RCHK(ic_pkg::LINE_OFS, 32'h0)
    `CHK({normal_n, fast_n}, 2'b11)
    rd(12'h200, rv);
    `CHK({err, rv}, {1'b1, 32'h0})
    for (k = 0; k < 32; k++) begin
      hnd[k] = $urandom();
      wr(ic_pkg::HANDLER_BASE + 12'(4 * k), hnd[k]);
    end
    // enable and disable commands
    wr(ic_pkg::ENABLE_OFS, 32'h0000_00F1);
    wr(ic_pkg::DISABLE_OFS, 32'h0000_0031);
    `RCHK(ic_pkg::MASK_OFS, 32'h0000_00C0)
    wr(ic_pkg::DISABLE_OFS, 32'hFFFF_FFFF);
    // level source ignores set and clear, masked source stays quiet
    wr(ma(2), mword(3'h7, 2'b00));
    src_in[2] <= 1'b1;
    wr(ic_pkg::CLEAR_OFS, 32'h4);
    `RCHK(ic_pkg::PENDING_OFS, 32'h4)
    `CHK(normal_n, 1'b1)
    src_in[2] <= 1'b0;
    wr(ic_pkg::SET_OFS, 32'h4);
    `RCHK(ic_pkg::PENDING_OFS, 32'h0)
    // edge source memory, pulse, clear and set
    wr(ma(3), mword(3'h5, 2'b01));
    src_in[3] <= 1'b1;
    @(posedge clock);
    src_in[3] <= 1'b0;
    `RCHK(ic_pkg::PENDING_OFS, 32'h8)
    wr(ic_pkg::CLEAR_OFS, 32'h8);
    `RCHK(ic_pkg::PENDING_OFS, 32'h0)
    wr(ic_pkg::SET_OFS, 32'h8);
    `RCHK(ic_pkg::PENDING_OFS, 32'h8)
    wr(ic_pkg::CLEAR_OFS, 32'h8);
    // priority choice, equal level waits for end of service
    for (k = 4; k < 7; k++) wr(ma(k), mword(k == 4 ? 3'h2 : 3'h6, 2'b01));
    wr(ic_pkg::SET_OFS, 32'h70);
    `CHK(normal_n, 1'b1)
    wr(ic_pkg::ENABLE_OFS, 32'h70);
    wait_req(1'b0);
    `RCHK(ic_pkg::LINE_OFS, 32'h2)
    `RCHK(ic_pkg::VECTOR_OFS, hnd[5])
    `RCHK(ic_pkg::CURRENT_OFS, 32'h5)
    `RCHK(ic_pkg::PENDING_OFS, 32'h50)
    `CHK(normal_n, 1'b1)
    wr(ic_pkg::EOS_OFS, 32'h0);
    wait_req(1'b0);
    `RCHK(ic_pkg::VECTOR_OFS, hnd[6])
    wr(ic_pkg::EOS_OFS, 32'h0);
    `RCHK(ic_pkg::VECTOR_OFS, hnd[4])
    wr(ic_pkg::EOS_OFS, 32'h0);
    `RCHK(ic_pkg::PENDING_OFS, 32'h0)
    // eight nested services, popped in reverse
    for (k = 0; k < 8; k++) wr(ma(20 + k), mword(3'(k), 2'b01));
    wr(ic_pkg::ENABLE_OFS, 32'h0FF0_0000);
    for (k = 0; k < 8; k++) begin
      wr(ic_pkg::SET_OFS, 32'h1 << (20 + k));
      wait_req(1'b0);
      `RCHK(ic_pkg::VECTOR_OFS, hnd[20 + k])
    end
    for (k = 7; k >= 0; k--) begin
      `RCHK(ic_pkg::CURRENT_OFS, 32'(20 + k))
      wr(ic_pkg::EOS_OFS, 32'h0);
    end
    // fast source, falling edge off the idle-high pin, cleared by fast vector read
    wr(ma(0), mword(3'h5, 2'b01));
    `RCHK(ma(0), 32'h25)
    wr(ic_pkg::ENABLE_OFS, 32'h1);
    fast_in <= 1'b0;
    wait_req(1'b1);
    `RCHK(ic_pkg::LINE_OFS, 32'h1)
    `CHK(normal_n, 1'b1)
    `RCHK(ic_pkg::FAST_VECTOR_OFS, hnd[0])
    `RCHK(ic_pkg::PENDING_OFS, 32'h0)
    `CHK(fast_n, 1'b1)
    fast_in <= 1'b1;
    // redirected source escapes the vector auto-clear
    wr(ic_pkg::FORCE_OFS, 32'h100);
    `RCHK(ic_pkg::FORCE_OFS, 32'h100)
    wr(ma(8), mword(3'h7, 2'b01));
    wr(ic_pkg::ENABLE_OFS, 32'h100);
    wr(ic_pkg::SET_OFS, 32'h100);
    wait_req(1'b1);
    `CHK(normal_n, 1'b1)
    rd(ic_pkg::VECTOR_OFS, rv);
    `RCHK(ic_pkg::PENDING_OFS, 32'h100)
    wr(ic_pkg::CLEAR_OFS, 32'h100);
    wr(ic_pkg::FORCE_OFS, 32'h0);
    // external source in all four trigger modes
    for (k = 0; k < 4; k++) begin
      src_in[31] <= ~k[1];
      wr(ma(31), mword(3'h1, 2'(k)));
      repeat (8) @(posedge clock);
      wr(ic_pkg::CLEAR_OFS, 32'h8000_0000);
      `RCHK(ic_pkg::PENDING_OFS, 32'h0)
      src_in[31] <= k[1];
      repeat (8) @(posedge clock);
      `RCHK(ic_pkg::PENDING_OFS, 32'h8000_0000)
    end
    // random priorities and pending sets
    wr(ic_pkg::DISABLE_OFS, 32'hFFFF_FFFF);
    wr(ic_pkg::ENABLE_OFS, 32'h0001_FE00);
    for (w = 0; w < 8; w++) begin
      for (k = 9; k < 17; k++) begin
        pr[k] = 3'($urandom());
        wr(ma(k), mword(pr[k], 2'b01));
      end
      mk = (w == 0) ? 32'h0001_FE00 : ($urandom() & 32'h0001_FE00);
      wr(ic_pkg::SET_OFS, mk);
      if (mk != 32'h0) begin
        `RCHK(ic_pkg::VECTOR_OFS, hnd[best(pr, mk)])
        `RCHK(ic_pkg::CURRENT_OFS, 32'(best(pr, mk)))
        wr(ic_pkg::EOS_OFS, 32'h0);
      end
      wr(ic_pkg::CLEAR_OFS, 32'h0001_FE00);
    end
    final_report();
  end
endmodule
